// File: src/dqr_pkg.sv
// Shared constants and carrier types for the data-acquisition register decode.
// Assumes an 8-bit host I/O bus with 10 address lines, sampled on core_clk.
package dqr_pkg;

  // Address window geometry.
  localparam int ADDR_W = 10;
  localparam int OFF_W = 4;
  localparam int BASE_LO = 4;
  localparam int SW_W = 6;

  // Register offsets inside the sixteen-location window.
  localparam logic [3:0] OFF_TMR0 = 4'h0;
  localparam logic [3:0] OFF_TMR2 = 4'h2;
  localparam logic [3:0] OFF_TMR_CTRL = 4'h3;
  localparam logic [3:0] OFF_RES_LO = 4'h4;
  localparam logic [3:0] OFF_RES_HI = 4'h5;
  localparam logic [3:0] OFF_DIN_LO = 4'h6;
  localparam logic [3:0] OFF_DIN_HI = 4'h7;
  localparam logic [3:0] OFF_IRQ_CLR = 4'h8;
  localparam logic [3:0] OFF_GAIN = 4'h9;
  localparam logic [3:0] OFF_CHAN = 4'hA;
  localparam logic [3:0] OFF_MODE = 4'hB;
  localparam logic [3:0] OFF_KICK = 4'hC;
  localparam logic [3:0] OFF_DOUT_LO = 4'hD;
  localparam logic [3:0] OFF_DOUT_HI = 4'hE;

  // Field positions.
  localparam int RDY_BIT = 4;
  localparam int HI_NIB_W = 4;
  localparam int SEL_W = 3;
  localparam int IRQSEL_LO = 4;
  localparam int PACER_BIT = 1;

  // Conversion mode that selects interrupt transfer.
  localparam logic [2:0] MODE_INTR = 3'h6;

  // Reset values.
  localparam logic RDY_RST = 1'h1;
  localparam logic [15:0] DOUT_RST = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // One host I/O cycle as seen on the pins.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rdN;
    logic wrN;
    logic aen;
    logic [7:0] data;
  } dqr_io_cycle_t;

  // Pass-through request to the embedded timer/counter.
  typedef struct packed {
    logic [1:0] addr;
    logic wrStb;
    logic rdStb;
    logic [7:0] data;
  } dqr_tmr_req_t;

  // Conversion results as delivered by the converter.
  typedef struct packed {
    logic done;
    logic [11:0] code;
  } dqr_adc_rsp_t;

endpackage

// File: src/dqr_out_latch.sv
// Sixteen-bit output latch loaded one byte lane at a time.
// Assumes one-cycle lane write enables from the register decode.
`timescale 1ns/1ps
module dqr_out_latch import dqr_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] laneWe,
  input wire logic [7:0] wrByte,
  output logic [15:0] latched
);

  logic [15:0] latch_r;
  logic [15:0] latch_nxt;

  // Each lane keeps its value until its own enable comes.
  always_comb begin
    latch_nxt = latch_r;
    for (int i = 0; i < 2; i++) begin
      if (laneWe[i]) begin
        latch_nxt[i*8 +: 8] = wrByte;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_r <= DOUT_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign latched = latch_r;

endmodule

// File: src/dqr_reg_decode.sv
// Host I/O register front end of the data-acquisition board.
// Assumes the host strobes, address and switch inputs are synchronous to core_clk.
// Contract
// - Sixteen consecutive ports from a switch-selected base.
// - Switches compare A9..A4; ON demands a zero.
// - Reads: timer, result, digital inputs; rest reserved.
// - Writes map timer, D/A, control, outputs.
// - Offsets 0 to 3 pass to timer on writes, 0 to 2 on reads.
// - Result low byte, high nibble, zero top.
// - Ready bit high until conversion completes.
// - D/A code low byte, then high nibble.
// - D/A double buffered, committed on high write.
// - Digital inputs read as two bytes.
// - Interrupt mode sets flag per conversion.
// - Any write to offset 8 clears flag.
// - Gain uses bits 2:0 only.
// - Channel select uses bits 2:0 only.
// - Any write to offset C triggers conversion.
// - Digital outputs latched by two byte writes.
`timescale 1ns/1ps
module dqr_reg_decode import dqr_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire dqr_io_cycle_t hostBus,
  input wire logic [SW_W-1:0] base_select_switch,
  input wire logic [7:0] tmrRdData,
  input wire dqr_adc_rsp_t adcRsp,
  input wire logic pacerTrig,
  input wire logic [15:0] digital_in_port,
  output logic [7:0] busRdData,
  output logic busRdOe,
  output dqr_tmr_req_t tmrReq,
  output logic adcStart,
  output logic [11:0] dacCode,
  output logic [15:0] digitalOut,
  output logic amp_select_bit2,
  output logic amp_select_bit1,
  output logic amp_select_bit0,
  output logic [SEL_W-1:0] inputChan,
  output logic [SEL_W-1:0] convMode,
  output logic [SEL_W-1:0] irqLineSel,
  output logic irqReq
);

  typedef struct packed {
    logic wrSeen;
    logic rdSeen;
    logic [7:0] rdData;
    logic rdOe;
    logic [7:0] dacStage;
    logic [11:0] dacOut;
    logic [11:0] adcData;
    logic adcPending;
    logic irqFlag;
    logic [SEL_W-1:0] gain;
    logic [SEL_W-1:0] chan;
    logic [SEL_W-1:0] mode;
    logic [SEL_W-1:0] irqSel;
    logic kick;
    dqr_tmr_req_t tmr;
  } dqr_state_t;

  dqr_state_t st_r;
  dqr_state_t st_nxt;

  // Offsets that answer a read; everything else stays off the data bus.
  function automatic logic offReadable(input logic [OFF_W-1:0] off);
    offReadable = (off <= OFF_TMR2) || (off >= OFF_RES_LO && off <= OFF_DIN_HI);
  endfunction

  // Offsets routed to the timer/counter for the given direction.
  function automatic logic offTimer(input logic [OFF_W-1:0] off, input logic isWrite);
    offTimer = isWrite ? (off <= OFF_TMR_CTRL) : (off <= OFF_TMR2);
  endfunction

  logic [OFF_W-1:0] offset;
  logic [SW_W-1:0] wantHigh;
  logic baseHit;
  logic rdActive;
  logic wrActive;
  logic wrPulse;
  logic rdPulse;
  logic trigger;
  logic [1:0] doutLaneWe;

  // A switch in the ON position asks for a zero on its address line.
  assign wantHigh = ~base_select_switch;
  // Only A9..A4 take part, so the board covers all sixteen low offsets.
  assign baseHit = (hostBus.addr[ADDR_W-1:BASE_LO] == wantHigh) && !hostBus.aen;
  assign offset = hostBus.addr[OFF_W-1:0];

  // Strobes are levels on the pins; one pulse per host cycle is cut at the
  // leading edge so a slow host cycle never repeats a side effect.
  assign rdActive = baseHit && !hostBus.rdN;
  assign wrActive = baseHit && !hostBus.wrN;
  assign wrPulse = wrActive && !st_r.wrSeen;
  assign rdPulse = rdActive && !st_r.rdSeen;

  // A conversion starts on a kick write or, in pacer modes, on the pacer.
  assign trigger = (wrPulse && offset == OFF_KICK) ||
                   (pacerTrig && st_r.mode[PACER_BIT]);

  // Digital output byte lanes, one per offset.
  assign doutLaneWe[0] = wrPulse && offset == OFF_DOUT_LO;
  assign doutLaneWe[1] = wrPulse && offset == OFF_DOUT_HI;

  // Next-state logic for the register file except the digital outputs, which sit in their own latch.
  always_comb begin
    st_nxt = st_r;
    st_nxt.wrSeen = wrActive;
    st_nxt.rdSeen = rdActive;
    st_nxt.kick = 1'b0;
    st_nxt.tmr.wrStb = 1'b0;
    st_nxt.tmr.rdStb = 1'b0;

    // Timer accesses go through with address and data held for the strobe.
    if (wrPulse && offTimer(offset, 1'b1)) begin
      st_nxt.tmr.wrStb = 1'b1;
      st_nxt.tmr.addr = offset[1:0];
      st_nxt.tmr.data = hostBus.data;
    end
    if (rdPulse && offTimer(offset, 1'b0)) begin
      st_nxt.tmr.rdStb = 1'b1;
      st_nxt.tmr.addr = offset[1:0];
    end

    // Write side of the map; reserved offsets fall to the default.
    if (wrPulse) begin
      case (offset)
        OFF_RES_LO: begin
          st_nxt.dacStage = hostBus.data; // Staged only.
        end
        OFF_RES_HI: begin
          // Upper nibble of the data is dropped.
          st_nxt.dacOut = {hostBus.data[HI_NIB_W-1:0], st_r.dacStage};
        end
        OFF_GAIN: begin
          st_nxt.gain = hostBus.data[SEL_W-1:0];
        end
        OFF_CHAN: begin
          st_nxt.chan = hostBus.data[SEL_W-1:0];
        end
        OFF_MODE: begin
          st_nxt.mode = hostBus.data[SEL_W-1:0];
          st_nxt.irqSel = hostBus.data[IRQSEL_LO +: SEL_W];
        end
        default: begin
          st_nxt.dacStage = st_r.dacStage;
        end
      endcase
    end

    // Any data at the kick offset starts a conversion.
    if (trigger) begin
      st_nxt.kick = 1'b1;
    end

    // A finished conversion stores the code and drops the pending flag.
    if (adcRsp.done) begin
      st_nxt.adcData = adcRsp.code;
      st_nxt.adcPending = 1'b0;
    end
    // A new trigger wins over a completion in the same cycle.
    if (trigger) begin
      st_nxt.adcPending = 1'b1;
    end

    // Interrupt status: the clear comes first so a completion in the same
    // cycle still raises the flag and no conversion is lost.
    if (wrPulse && offset == OFF_IRQ_CLR) begin
      st_nxt.irqFlag = 1'b0;
    end
    if (adcRsp.done && st_r.mode == MODE_INTR) begin
      st_nxt.irqFlag = 1'b1;
    end

    // Read data is refreshed every cycle of the read, so a timer answer that
    // arrives late still reaches the bus before the strobe is released.
    st_nxt.rdOe = rdActive && offReadable(offset);
    st_nxt.rdData = BYTE_ZERO;
    if (rdActive) begin
      case (offset)
        OFF_RES_LO: begin
          st_nxt.rdData = st_r.adcData[7:0];
        end
        OFF_RES_HI: begin
          // Bits 7:5 read zero, bit 4 is the not-ready flag.
          st_nxt.rdData = BYTE_ZERO;
          st_nxt.rdData[HI_NIB_W-1:0] = st_r.adcData[11:8];
          st_nxt.rdData[RDY_BIT] = st_r.adcPending;
        end
        OFF_DIN_LO: begin
          st_nxt.rdData = digital_in_port[7:0];
        end
        OFF_DIN_HI: begin
          st_nxt.rdData = digital_in_port[15:8];
        end
        default: begin
          if (offTimer(offset, 1'b0)) begin
            st_nxt.rdData = tmrRdData;
          end
        end
      endcase
    end
  end

  // State register; the result reads not-ready until a conversion ends.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.adcPending <= RDY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Digital outputs live in their own byte-lane latch.
  dqr_out_latch doutLatch (
    .core_clk(core_clk),
    .rst(rst),
    .laneWe(doutLaneWe),
    .wrByte(hostBus.data),
    .latched(digitalOut)
  );

  // Outputs come straight from the state register.
  assign busRdData = st_r.rdData;
  assign busRdOe = st_r.rdOe;
  assign tmrReq = st_r.tmr;
  assign adcStart = st_r.kick;
  assign dacCode = st_r.dacOut;
  assign amp_select_bit2 = st_r.gain[2];
  assign amp_select_bit1 = st_r.gain[1];
  assign amp_select_bit0 = st_r.gain[0];
  assign inputChan = st_r.chan;
  assign convMode = st_r.mode;
  assign irqLineSel = st_r.irqSel;
  assign irqReq = st_r.irqFlag;

  default clocking dqrCk @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Checks kept beside the logic they guard.
  // A pacer pulse right after the kick would legally start a second conversion.
  a_kick_one_pulse: assert property (
    (wrPulse && offset == OFF_KICK) ##1 !(pacerTrig && st_r.mode[PACER_BIT]) |->
      adcStart ##1 !adcStart)
    else $error("kick write did not give one start pulse");

  a_pending_set: assert property (
    adcStart |-> st_r.adcPending)
    else $error("pending flag not set after trigger");

  a_ready_clears: assert property (
    (adcRsp.done && !trigger) |=> !st_r.adcPending)
    else $error("ready bit not cleared after conversion");

  a_irq_set: assert property (
    (adcRsp.done && convMode == MODE_INTR) |=> irqReq)
    else $error("interrupt flag not raised in interrupt mode");

  a_irq_clear: assert property (
    (wrPulse && offset == OFF_IRQ_CLR && !adcRsp.done) |=> !irqReq)
    else $error("interrupt flag survived a clear write");

  a_dac_commit: assert property (
    (wrPulse && offset == OFF_RES_HI) |=>
      dacCode == {$past(hostBus.data[3:0]), $past(st_r.dacStage)})
    else $error("D/A code not committed from stage and high nibble");

  a_dac_hold_low: assert property (
    (wrPulse && offset == OFF_RES_LO) |=> $stable(dacCode))
    else $error("D/A output moved on a low byte write");

  a_reserved_quiet: assert property (
    (rdActive && !offReadable(offset)) |=> !busRdOe)
    else $error("data bus driven on a reserved read");

  a_miss_quiet: assert property (
    (!baseHit && !pacerTrig) |=> !busRdOe && !tmrReq.wrStb && !adcStart)
    else $error("access outside the window had an effect");

  a_result_high: assert property (
    (rdActive && offset == OFF_RES_HI) |=>
      busRdData[7:5] == 3'h0 && busRdData[3:0] == $past(st_r.adcData[11:8]))
    else $error("result high byte malformed");

  a_timer_write: assert property (
    (wrPulse && offTimer(offset, 1'b1)) |=> tmrReq.wrStb &&
      tmrReq.addr == $past(offset[1:0]) && tmrReq.data == $past(hostBus.data))
    else $error("timer write not passed through");

  a_timer_read: assert property (
    (rdPulse && offTimer(offset, 1'b0)) |=>
      tmrReq.rdStb && tmrReq.addr == $past(offset[1:0]))
    else $error("timer read not passed through");

  a_result_low: assert property (
    (rdActive && offset == OFF_RES_LO) |=>
      busRdOe && busRdData == $past(st_r.adcData[7:0]))
    else $error("result low byte malformed");

  a_din_low: assert property (
    (rdActive && offset == OFF_DIN_LO) |=>
      busRdOe && busRdData == $past(digital_in_port[7:0]))
    else $error("digital input low byte not returned");

  a_din_high: assert property (
    (rdActive && offset == OFF_DIN_HI) |=>
      busRdOe && busRdData == $past(digital_in_port[15:8]))
    else $error("digital input high byte not returned");

  a_gain_field: assert property (
    (wrPulse && offset == OFF_GAIN) |=>
      {amp_select_bit2, amp_select_bit1, amp_select_bit0} == $past(hostBus.data[SEL_W-1:0]))
    else $error("gain code not taken from the low bits");

  a_chan_field: assert property (
    (wrPulse && offset == OFF_CHAN) |=>
      inputChan == $past(hostBus.data[SEL_W-1:0]))
    else $error("channel number not taken from the low bits");

  a_dout_low: assert property (
    (wrPulse && offset == OFF_DOUT_LO) |=>
      digitalOut[7:0] == $past(hostBus.data) && $stable(digitalOut[15:8]))
    else $error("digital output low lane not latched alone");

  a_dout_high: assert property (
    (wrPulse && offset == OFF_DOUT_HI) |=>
      digitalOut[15:8] == $past(hostBus.data) && $stable(digitalOut[7:0]))
    else $error("digital output high lane not latched alone");

  a_irq_hold: assert property (
    (irqReq && !(wrPulse && offset == OFF_IRQ_CLR)) |=> irqReq)
    else $error("interrupt flag dropped without a clear write");

  a_reserved_write: assert property (
    (wrPulse && (offset == OFF_DIN_LO || offset == OFF_DIN_HI || offset > OFF_DOUT_HI)) |=>
      $stable(dacCode) && $stable(digitalOut) && !tmrReq.wrStb)
    else $error("reserved write had an effect");

  a_pending_on_trigger: assert property (
    trigger |=> st_r.adcPending)
    else $error("pending flag not set by a trigger");

endmodule

// File: tb/dqr_host_model.sv
// Host CPU model that runs I/O read and write cycles on the board pins.
// Assumes strobes are sampled on core_clk rising edges; it drives on falling edges.
`timescale 1ns/1ps
module dqr_host_model import dqr_pkg::*; (
  input wire logic core_clk,
  input wire logic [9:0] base,
  input wire logic [1:0] idleGap,
  output dqr_io_cycle_t bus,
  output logic sample
);
  // Idle bus at time zero: both strobes high, no DMA cycle.
  initial begin
    bus = '{addr: 10'h000, rdN: 1'b1, wrN: 1'b1, aen: 1'b0, data: 8'h00};
    sample = 1'b0;
  end

  // One write; the data is inverted on release so a stale byte never looks valid.
  task automatic wr(input logic [3:0] off, input logic [7:0] d);
    repeat (idleGap) @(negedge core_clk);
    @(negedge core_clk);
    bus.addr = {base[9:4], off};
    bus.data = d;
    bus.wrN = 1'b0;
    @(negedge core_clk);
    bus.wrN = 1'b1;
    bus.data = ~d;
  endtask

  // One read; sample marks the cycle in which the registered answer is settled.
  task automatic rd(input logic [3:0] off);
    repeat (idleGap) @(negedge core_clk);
    @(negedge core_clk);
    bus.addr = {base[9:4], off};
    bus.rdN = 1'b0;
    repeat (2) @(negedge core_clk);
    sample = 1'b1;
    @(negedge core_clk);
    sample = 1'b0;
    bus.rdN = 1'b1;
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the register decode; the host model issues all bus cycles.
// Assumes the decode answers reads one cycle after the strobe is taken.
`timescale 1ns/1ps
module tb_top import dqr_pkg::*; ();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  dqr_io_cycle_t hostBus;
  logic [5:0] sw = 6'h1D;
  logic [9:0] hostBase = 10'h220;
  logic [1:0] idleGap = 2'h0;
  logic [7:0] tmrRdData = 8'h00;
  dqr_adc_rsp_t adcRsp = '0;
  logic [15:0] din = 16'h0000;
  logic [7:0] busRdData;
  logic busRdOe;
  dqr_tmr_req_t tmrReq;
  logic adcStart;
  logic [11:0] dacCode;
  logic [15:0] digitalOut;
  logic g2, g1, g0, irqReq, sample;
  logic [2:0] inputChan, convMode, irqLineSel;
  logic pacerTrig = 1'b0;
  logic [15:0] tmrRdCount = 16'h0000;
  logic [8:0] expQ[$];
  logic [31:0] v;
  integer seed, fails = 0, checksDone = 0;
  int settle[5] = '{210, 250, 270, 360, 410};

  dqr_host_model host (.core_clk(core_clk), .base(hostBase), .idleGap(idleGap),
    .bus(hostBus), .sample(sample));
  dqr_reg_decode dut (.core_clk(core_clk), .rst(rst), .hostBus(hostBus),
    .base_select_switch(sw), .tmrRdData(tmrRdData), .adcRsp(adcRsp), .pacerTrig(pacerTrig),
    .digital_in_port(din), .busRdData(busRdData), .busRdOe(busRdOe), .tmrReq(tmrReq),
    .adcStart(adcStart), .dacCode(dacCode), .digitalOut(digitalOut),
    .amp_select_bit2(g2), .amp_select_bit1(g1), .amp_select_bit0(g0),
    .inputChan(inputChan), .convMode(convMode), .irqLineSel(irqLineSel), .irqReq(irqReq));

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  // Counts timer read strobes on the falling edge, away from the launching edge.
  always @(negedge core_clk) begin
    if (tmrReq.rdStb) begin
      tmrRdCount = tmrRdCount + 16'h0001;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Notes the expected {enable, byte} and runs the read.
  task automatic rdx(input logic [3:0] off, input logic [8:0] e);
    expQ.push_back(e);
    host.rd(off);
  endtask

  // Oldest note against the settled answer; a refused read only checks the enable.
  always @(posedge sample) begin
    logic [8:0] e;
    e = expQ.pop_front();
    if (e[8]) begin
      chk("read", {7'h00, e}, {7'h00, busRdOe, busRdData});
    end else begin
      chk("read enable", 16'h0000, {15'h0000, busRdOe});
    end
  end

  task automatic giveVerdict();
    $display("Checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well above the roughly 1700 cycles the tests take.
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    giveVerdict();
  end

  // Main sequence.
  initial begin
    seed = 32'h6EF1894C;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    rdx(OFF_RES_HI, 9'h110);
    v = $random(seed);
    din = v[15:0];
    rdx(OFF_DIN_LO, {1'b1, din[7:0]});
    rdx(OFF_DIN_HI, {1'b1, din[15:8]});
    rdx(OFF_TMR_CTRL, 9'h000);
    for (int i = 8; i < 16; i++) rdx(i[3:0], 9'h000);
    host.wr(4'hF, 8'hFF);
    host.wr(OFF_DIN_HI, 8'hFF);
    chk("dout", 16'h0000, digitalOut);
    hostBase = 10'h230;
    rdx(OFF_DIN_LO, 9'h000);
    host.wr(OFF_DOUT_LO, 8'hA5);
    chk("dout", 16'h0000, digitalOut);
    v = $random(seed);
    sw = v[5:0];
    hostBase = {~v[5:0], 4'h0};
    rdx(OFF_DIN_HI, {1'b1, din[15:8]});
    $display("Test decode done");
    v = $random(seed);
    host.wr(OFF_RES_LO, v[7:0]);
    chk("dac", 16'h0000, {4'h0, dacCode});
    host.wr(OFF_RES_HI, v[15:8]);
    chk("dac", {4'h0, v[11:8], v[7:0]}, {4'h0, dacCode});
    host.wr(OFF_DOUT_LO, v[23:16]);
    chk("dout", {8'h00, v[23:16]}, digitalOut);
    host.wr(OFF_DOUT_HI, v[31:24]);
    chk("dout", v[31:16], digitalOut);
    $display("Test outputs done");
    idleGap = 2'h2;
    for (int g = 0; g < 5; g++) begin
      v = $random(seed);
      host.wr(OFF_GAIN, {v[4:0], g[2:0]});
      chk("gain", {13'h0, g[2:0]}, {13'h0, g2, g1, g0});
      repeat (settle[g]) @(negedge core_clk);
    end
    for (int c = 0; c < 8; c++) begin
      v = $random(seed);
      host.wr(OFF_CHAN, {v[4:0], c[2:0]});
      chk("chan", {13'h0, c[2:0]}, {13'h0, inputChan});
    end
    $display("Test select done");
    host.wr(OFF_MODE, {1'b0, 3'h5, 1'b0, MODE_INTR});
    chk("mode", {13'h0, MODE_INTR}, {13'h0, convMode});
    chk("irq line", 16'h0005, {13'h0, irqLineSel});
    host.wr(OFF_KICK, v[15:8]);
    chk("start", 16'h0001, {15'h0, adcStart});
    @(negedge core_clk);
    chk("start", 16'h0000, {15'h0, adcStart});
    rdx(OFF_RES_HI, 9'h110);
    v = $random(seed);
    adcRsp = '{done: 1'b1, code: v[11:0]};
    @(negedge core_clk);
    adcRsp.done = 1'b0;
    chk("irq", 16'h0001, {15'h0, irqReq});
    rdx(OFF_RES_LO, {1'b1, v[7:0]});
    rdx(OFF_RES_HI, {5'h10, v[11:8]});
    host.wr(OFF_IRQ_CLR, v[23:16]);
    chk("irq", 16'h0000, {15'h0, irqReq});
    pacerTrig = 1'b1;
    @(negedge core_clk);
    pacerTrig = 1'b0;
    chk("start", 16'h0001, {15'h0, adcStart});
    rdx(OFF_RES_HI, {5'h11, v[11:8]});
    $display("Test convert done");
    tmrRdData = v[31:24];
    host.wr(4'h1, v[19:12]);
    chk("timer strobe", 16'h0001, {15'h0, tmrReq.wrStb});
    chk("timer word", {6'h0, 2'h1, v[19:12]}, {6'h0, tmrReq.addr, tmrReq.data});
    rdx(OFF_TMR2, {1'b1, v[31:24]});
    chk("timer reads", 16'h0001, tmrRdCount);
    $display("Test timer done");
    giveVerdict();
  end
endmodule
